// ===== hw/tsf_event_flags.sv
// module: status flags, software event generation and register slave of the timer
`timescale 1ns/100ps
`default_nettype none

module tsf_event_flags
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic brake_pin,
  input wire tsf_pkg::tsf_core_ev_t core_ev,
  output tsf_pkg::tsf_core_cmd_t core_cmd,
  output logic timer_irq,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import tsf_pkg::*;

  typedef enum {SEL_CONFIG, SEL_ENABLE, SEL_FLAGS, SEL_FORCE, SEL_NONE} tsf_sel_t;

  function automatic tsf_sel_t decode(input logic [7:0] addr);
    case (addr)
      OFS_CONFIG: decode = SEL_CONFIG;
      OFS_ENABLE: decode = SEL_ENABLE;
      OFS_FLAGS: decode = SEL_FLAGS;
      OFS_FORCE: decode = SEL_FORCE;
      default: decode = SEL_NONE;
    endcase
  endfunction : decode

  function automatic logic [31:0] lane_mask(input logic [3:0] strb);
    lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction : lane_mask

  //////////////////////////////////////////////////////////////////////////////
  // register state

  logic [31:0] config_reg;
  logic [14:0] enable_reg;
  logic [17:0] flags;
  logic [7:0] force_pulse;
  logic brake_meta;
  logic brake_sync;

  logic aw_got;
  logic w_got;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  tsf_sel_t wr_sel;
  logic [31:0] wr_mask;

  logic update_disable;
  logic update_req_src;
  logic chan_preload;
  logic slave_gated;
  logic count_down;
  logic [1:0] center_align_select;
  logic [5:0] chan_input_mode;

  assign update_disable = config_reg[CFG_UPDATE_DISABLE];
  assign update_req_src = config_reg[CFG_UPDATE_REQ_SRC];
  assign chan_preload = config_reg[CFG_CHAN_PRELOAD];
  assign slave_gated = config_reg[CFG_SLAVE_GATED];
  assign count_down = config_reg[CFG_COUNT_DOWN];
  assign center_align_select = config_reg[CFG_CENTER_LO +: 2];
  assign chan_input_mode = config_reg[CFG_INPUT_MODE_LO +: 6];

  //////////////////////////////////////////////////////////////////////////////
  // axi4-lite write channel: address and data taken in either order

  assign do_write = aw_got && w_got && !s_axi_bvalid;
  assign wr_sel = decode(aw_addr);
  assign wr_mask = lane_mask(w_strb);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got <= 1'b0;
      aw_addr <= 8'h00;
      s_axi_awready <= 1'b0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_got <= 1'b1;
      aw_addr <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end
    else if (do_write)
    begin
      aw_got <= 1'b0;
    end
    else if (!aw_got && !s_axi_bvalid)
    begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_got <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_wready <= 1'b0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_got <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end
    else if (do_write)
    begin
      w_got <= 1'b0;
    end
    else if (!w_got && !s_axi_bvalid)
    begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end
    else if (s_axi_bready)
    begin
      s_axi_bvalid <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // axi4-lite read channel

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      case (decode(s_axi_araddr))
        SEL_CONFIG: s_axi_rdata <= config_reg;
        SEL_ENABLE: s_axi_rdata <= {17'h0_0000, enable_reg};
        SEL_FLAGS: s_axi_rdata <= {14'h0000, flags};
        SEL_FORCE: s_axi_rdata <= 32'h0000_0000; // write-only, reads reset value
        default:
        begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rvalid)
    begin
      if (s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
    end
    else
    begin
      s_axi_arready <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // control registers

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      config_reg <= RST_CONFIG;
    end
    else if (do_write && wr_sel == SEL_CONFIG)
    begin
      config_reg <= (config_reg & ~wr_mask) | (w_data & wr_mask & CFG_USED);
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      enable_reg <= RST_ENABLE;
    end
    else if (do_write && wr_sel == SEL_ENABLE)
    begin
      enable_reg <= (enable_reg & ~wr_mask[14:0]) | (w_data[14:0] & wr_mask[14:0]);
    end
  end

  // force bits live one cycle only, so they clear themselves
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      force_pulse <= 8'h00;
    end
    else if (do_write && wr_sel == SEL_FORCE && w_strb[0])
    begin
      force_pulse <= w_data[7:0]; // zeros do nothing
    end
    else
    begin
      force_pulse <= 8'h00;
    end
  end

  // brake pin is asynchronous to aclk
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      brake_meta <= 1'b0;
      brake_sync <= 1'b0;
    end
    else
    begin
      brake_meta <= brake_pin;
      brake_sync <= brake_meta;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // flag set and clear terms

  logic [17:0] set_flags;
  logic [17:0] clr_flags;
  logic [5:0] chan_set;
  logic [5:0] compare_hit;
  logic [3:0] soft_chan;
  logic update_set;
  logic trig_set;
  logic com_set;
  logic brake_set;

  assign soft_chan = force_pulse[BIT_CH1_FORCE +: 4];

  always_comb
  begin
    compare_hit = 6'h00;
    for (int i = 0; i < 6; i++)
    begin
      // center-aligned: 01 counts matches only while counting down, 10 only while counting up, 11 in both
      case (center_align_select)
        2'b00: compare_hit[i] = core_ev.compare_match[i];
        2'b01: compare_hit[i] = core_ev.compare_match[i] && !core_ev.count_up;
        2'b10: compare_hit[i] = core_ev.compare_match[i] && core_ev.count_up;
        default: compare_hit[i] = core_ev.compare_match[i];
      endcase
      // compare beyond reload fires on wrap
      compare_hit[i] = compare_hit[i] || (core_ev.compare_above_reload[i] && core_ev.counter_wrap);
    end
  end

  always_comb
  begin
    chan_set = 6'h00;
    for (int i = 0; i < 6; i++)
    begin
      if (chan_input_mode[i])
      begin
        chan_set[i] = core_ev.capture[i];
      end
      else
      begin
        chan_set[i] = compare_hit[i];
      end
    end
    // software force on channels 1-4, output or input mode
    chan_set[3:0] = chan_set[3:0] | soft_chan;
  end

  // update: repetition reload, or reinit when request source allows
  assign update_set = !update_disable && (core_ev.rep_update ||
                      (!update_req_src && (force_pulse[BIT_UPDATE_FORCE] || core_ev.slave_reinit)));
  assign trig_set = (slave_gated ? core_ev.trig_any_edge : core_ev.trig_active_edge)
                    || force_pulse[BIT_TRIG_FORCE];
  assign com_set = core_ev.commutation_done || force_pulse[BIT_COM_FORCE];
  assign brake_set = brake_sync || force_pulse[BIT_BRAKE_FORCE];

  always_comb
  begin
    set_flags = 18'h0_0000;
    set_flags[BIT_UPDATE] = update_set;
    set_flags[BIT_CH1 +: 4] = chan_set[3:0];
    set_flags[BIT_COM] = com_set;
    set_flags[BIT_TRIG] = trig_set;
    set_flags[BIT_BRAKE] = brake_set;
    set_flags[BIT_CH5] = chan_set[4];
    set_flags[BIT_CH6] = chan_set[5];
    for (int i = 0; i < 4; i++)
    begin
      // a second capture on a pending flag is an overcapture
      set_flags[BIT_OVR1 + i] = chan_input_mode[i] && chan_set[i] && flags[BIT_CH1 + i];
    end
  end

  always_comb
  begin
    clr_flags = 18'h0_0000;
    if (do_write && wr_sel == SEL_FLAGS)
    begin
      clr_flags = ~w_data[17:0] & wr_mask[17:0] & FLAGS_USED;
    end
    // reading a capture register clears its flag
    for (int i = 0; i < 4; i++)
    begin
      clr_flags[BIT_CH1 + i] = clr_flags[BIT_CH1 + i] || (chan_input_mode[i] && core_ev.capture_read[i]);
    end
    clr_flags[BIT_CH5] = clr_flags[BIT_CH5] || (chan_input_mode[4] && core_ev.capture_read[4]);
    clr_flags[BIT_CH6] = clr_flags[BIT_CH6] || (chan_input_mode[5] && core_ev.capture_read[5]);
    // brake flag will not clear while the input stays active
    if (brake_sync)
    begin
      clr_flags[BIT_BRAKE] = 1'b0;
    end
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      flags <= RST_FLAGS;
    end
    else
    begin
      flags <= (flags & ~clr_flags) | set_flags;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // requests and commands to the timer core

  logic [7:0] irq_src;
  logic [6:0] dma_src;

  assign irq_src = flags[7:0];
  assign dma_src = {trig_set, com_set, chan_set[3:0], update_set};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      timer_irq <= 1'b0;
    end
    else
    begin
      timer_irq <= |(irq_src & enable_reg[7:0]);
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      core_cmd <= '0;
    end
    else
    begin
      core_cmd.dma_req <= dma_src & enable_reg[BIT_DMA_BASE +: 7];
      // update force always reloads counter and prescaler
      core_cmd.counter_reinit <= force_pulse[BIT_UPDATE_FORCE];
      core_cmd.reinit_to_reload <= force_pulse[BIT_UPDATE_FORCE] && count_down
                                   && center_align_select == 2'b00;
      core_cmd.soft_capture <= soft_chan & chan_input_mode[3:0];
      core_cmd.commutation_load <= force_pulse[BIT_COM_FORCE] && chan_preload;
      core_cmd.trigger_event <= force_pulse[BIT_TRIG_FORCE];
      core_cmd.main_output_clear <= brake_set;
    end
  end

endmodule : tsf_event_flags

`default_nettype wire

// ===== hw/tsf_pkg.sv
// package: register map, field layout and carrier types of the timer event flag block
package tsf_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_ENABLE = 8'h0c;
  localparam logic [7:0] OFS_FLAGS = 8'h10;
  localparam logic [7:0] OFS_FORCE = 8'h14;

  // reset values
  localparam logic [31:0] RST_CONFIG = 32'h0000_0000;
  localparam logic [14:0] RST_ENABLE = 15'h0000;
  localparam logic [17:0] RST_FLAGS = 18'h0_0000;

  // flag register layout
  localparam int BIT_UPDATE = 0;
  localparam int BIT_CH1 = 1;
  localparam int BIT_COM = 5;
  localparam int BIT_TRIG = 6;
  localparam int BIT_BRAKE = 7;
  localparam int BIT_OVR1 = 9;
  localparam int BIT_CH5 = 16;
  localparam int BIT_CH6 = 17;
  localparam logic [17:0] FLAGS_USED = 18'h3_1eff;

  // force register layout (channel force bits start at bit 1)
  localparam int BIT_UPDATE_FORCE = 0;
  localparam int BIT_CH1_FORCE = 1;
  localparam int BIT_COM_FORCE = 5;
  localparam int BIT_TRIG_FORCE = 6;
  localparam int BIT_BRAKE_FORCE = 7;

  // enable register layout: interrupts 7:0, dma 14:8
  localparam int BIT_DMA_BASE = 8;

  // config register layout
  localparam int CFG_UPDATE_DISABLE = 0;
  localparam int CFG_UPDATE_REQ_SRC = 1;
  localparam int CFG_CHAN_PRELOAD = 2;
  localparam int CFG_SLAVE_GATED = 3;
  localparam int CFG_COUNT_DOWN = 4;
  localparam int CFG_CENTER_LO = 5;
  localparam int CFG_INPUT_MODE_LO = 8;
  localparam logic [31:0] CFG_USED = 32'h0000_3f7f;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // events from the timer core, same clock
  typedef struct packed {
    logic [5:0] capture;
    logic [5:0] compare_match;
    logic count_up;
    logic [5:0] compare_above_reload;
    logic counter_wrap;
    logic rep_update;
    logic slave_reinit;
    logic trig_active_edge;
    logic trig_any_edge;
    logic commutation_done;
    logic [5:0] capture_read;
  } tsf_core_ev_t;

  // commands back to the timer core, one-cycle pulses except main_output_clear, which stays high while the brake is active
  typedef struct packed {
    logic counter_reinit;
    logic reinit_to_reload;
    logic [3:0] soft_capture;
    logic commutation_load;
    logic trigger_event;
    logic main_output_clear;
    logic [6:0] dma_req;
  } tsf_core_cmd_t;

endpackage : tsf_pkg

// ===== verif/tsf_event_flags_checker.sv
// checker: port-level assertions for the timer event flag block
`timescale 1ns/100ps
`default_nettype none
module tsf_event_flags_checker
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic brake_pin,
  input wire tsf_pkg::tsf_core_cmd_t core_cmd,
  input wire logic timer_irq,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import tsf_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////
  // five edges cover the two-flop synchroniser plus the command register stage
  AST_BRAKE_OFF: assert property (brake_pin [*5] |-> core_cmd.main_output_clear)
    else $error("brake held but outputs not cleared");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_B_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  AST_ERR_ZERO: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0)
    else $error("error read returned data");
  AST_TRIG_PULSE: assert property (core_cmd.trigger_event |=> !core_cmd.trigger_event)
    else $error("trigger pulse too long");
  AST_RELOAD: assert property (core_cmd.reinit_to_reload |-> core_cmd.counter_reinit)
    else $error("reload without reinit");
  AST_CAP_PULSE: assert property (|core_cmd.soft_capture |=> core_cmd.soft_capture == 4'h0)
    else $error("capture pulse too long");
  COV_BRAKE: cover property (core_cmd.main_output_clear);
  COV_TRIG: cover property (core_cmd.trigger_event);
  COV_IRQ: cover property ($rose(timer_irq));
endmodule : tsf_event_flags_checker
bind tsf_event_flags tsf_event_flags_checker u_tsf_event_flags_checker (
  .aclk(aclk),
  .aresetn(aresetn),
  .brake_pin(brake_pin),
  .core_cmd(core_cmd),
  .timer_irq(timer_irq),
  .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready)
);
`default_nettype wire

// ===== verif/tb_tsf_event_flags.sv
// testbench: self-checking bench for the timer event flag block
`timescale 1ns/100ps
`default_nettype none
module tb_tsf_event_flags;
  import tsf_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic brake_pin = 1'b0;
  tsf_core_ev_t core_ev = '0;
  tsf_core_ev_t e;
  tsf_core_cmd_t core_cmd;
  tsf_core_cmd_t cmd_or = '0;
  logic timer_irq, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, rs;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [33:0] exp_q[$];
  int miscompares = 0, samples_checked = 0, cyc = 0;

  tsf_event_flags u_tsf_event_flags (
    .aclk(aclk),
    .aresetn(aresetn),
    .brake_pin(brake_pin),
    .core_ev(core_ev),
    .core_cmd(core_cmd),
    .timer_irq(timer_irq),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready)
  );
  initial forever #2.5 aclk = ~aclk;

  ////////////////////////////////////////
  task automatic chk(input logic [33:0] seen, input logic [33:0] want);
    samples_checked++;
    if (seen !== want)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, want);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : report_and_stop

  // results appear strictly in issue order, since one access runs at a time
  always @(posedge aclk)
  begin
    cyc++;
    if (aresetn)
      cmd_or <= cmd_or | core_cmd;
    if (s_axi_bvalid && s_axi_bready)
      chk({s_axi_bresp, 32'h0}, exp_q.pop_front());
    if (s_axi_rvalid && s_axi_rready)
      chk({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
    if (cyc == 20000)
    begin
      miscompares++;
      report_and_stop();
    end
  end

  ////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    exp_q.push_back({r, 32'h0});
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    // ready raised late so the slave must hold its response a cycle
    do
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && !s_axi_bready)
        s_axi_bready <= 1'b1;
    end
    while (!(s_axi_bvalid && s_axi_bready));
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [1:0] r);
    exp_q.push_back({r, x});
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && !s_axi_rready)
        s_axi_rready <= 1'b1;
    end
    while (!(s_axi_rvalid && s_axi_rready));
    s_axi_rready <= 1'b0;
  endtask : rd

  task automatic ev(input tsf_core_ev_t v);
    @(posedge aclk);
    core_ev <= v;
    @(posedge aclk);
    core_ev <= '0;
  endtask : ev

  task automatic evchk(input logic [31:0] c, input tsf_core_ev_t v, input logic [31:0] x);
    wr(OFS_CONFIG, c, RESP_OKAY);
    ev(v);
    rd(OFS_FLAGS, x, RESP_OKAY);
    wr(OFS_FLAGS, 32'h0, RESP_OKAY);
  endtask : evchk

  function automatic int ci(input int i);
    return i < 4 ? i + 1 : i + 12;
  endfunction : ci

  ////////////////////////////////////////
  initial
  begin
    rs = $urandom(32'h3983);
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFS_FLAGS, 32'h0, RESP_OKAY);
    rd(OFS_ENABLE, 32'h0, RESP_OKAY);
    wr(OFS_FORCE, 32'h0, RESP_OKAY);
    rd(OFS_FORCE, 32'h0, RESP_OKAY);
    rd(8'h20, 32'h0, RESP_SLVERR);
    wr(8'h20, 32'hffff_ffff, RESP_SLVERR);
    $display("test reset done");
    // ch1 input, count down, preload on: every force bit has a visible effect
    wr(OFS_ENABLE, 32'h7fff, RESP_OKAY);
    wr(OFS_CONFIG, 32'h114, RESP_OKAY);
    wr(OFS_FORCE, 32'hff, RESP_OKAY);
    rd(OFS_FORCE, 32'h0, RESP_OKAY);
    rd(OFS_FLAGS, 32'hff, RESP_OKAY);
    chk({18'h0, cmd_or}, 34'hc7ff);
    chk({33'h0, timer_irq}, 34'h1);
    rs = $urandom;
    wr(OFS_FLAGS, rs, RESP_OKAY);
    rd(OFS_FLAGS, rs & 32'hff, RESP_OKAY);
    wr(OFS_FLAGS, 32'h0, RESP_OKAY);
    $display("test force done");
    evchk(32'h114, '{capture: 6'h01, default: '0}, 32'h2);
    e = '{capture: 6'h01, default: '0};
    ev(e);
    ev(e);
    ev('{capture_read: 6'h01, default: '0});
    rd(OFS_FLAGS, 32'h200, RESP_OKAY);
    wr(OFS_FORCE, 32'h2, RESP_OKAY);
    wr(OFS_FORCE, 32'h2, RESP_OKAY);
    rd(OFS_FLAGS, 32'h202, RESP_OKAY);
    wr(OFS_FLAGS, 32'h0, RESP_OKAY);
    $display("test capture done");
    for (int i = 0; i < 6; i++)
    begin
      e = '0;
      e.compare_match[i] = 1'b1;
      evchk(32'h0, e, 32'h1 << ci(i));
    end
    evchk(32'h20, '{compare_match: 6'h01, count_up: 1'b1, default: '0}, 32'h0);
    evchk(32'h20, '{compare_match: 6'h01, default: '0}, 32'h2);
    evchk(32'h0, '{compare_above_reload: 6'h01, counter_wrap: 1'b1, count_up: 1'b1, default: '0}, 32'h2);
    evchk(32'h0, '{rep_update: 1'b1, default: '0}, 32'h1);
    evchk(32'h1, '{rep_update: 1'b1, default: '0}, 32'h0);
    evchk(32'h0, '{slave_reinit: 1'b1, default: '0}, 32'h1);
    evchk(32'h2, '{slave_reinit: 1'b1, default: '0}, 32'h0);
    evchk(32'h0, '{trig_active_edge: 1'b1, default: '0}, 32'h40);
    evchk(32'h0, '{trig_any_edge: 1'b1, default: '0}, 32'h0);
    evchk(32'h8, '{trig_any_edge: 1'b1, default: '0}, 32'h40);
    evchk(32'h0, '{commutation_done: 1'b1, default: '0}, 32'h20);
    wr(OFS_CONFIG, 32'h2, RESP_OKAY);
    wr(OFS_FORCE, 32'h1, RESP_OKAY);
    rd(OFS_FLAGS, 32'h0, RESP_OKAY);
    $display("test events done");
    wr(OFS_ENABLE, 32'h80, RESP_OKAY);
    ev('{rep_update: 1'b1, default: '0});
    repeat (3) @(posedge aclk);
    chk({33'h0, timer_irq}, 34'h0);
    brake_pin <= 1'b1;
    repeat (6) @(posedge aclk);
    wr(OFS_FLAGS, 32'h0, RESP_OKAY);
    rd(OFS_FLAGS, 32'h80, RESP_OKAY);
    chk({33'h0, timer_irq}, 34'h1);
    brake_pin <= 1'b0;
    repeat (6) @(posedge aclk);
    wr(OFS_FLAGS, 32'h0, RESP_OKAY);
    rd(OFS_FLAGS, 32'h0, RESP_OKAY);
    chk({33'h0, timer_irq}, 34'h0);
    $display("test brake done");
    report_and_stop();
  end
endmodule : tb_tsf_event_flags
`default_nettype wire
